// *** hpr_pkg.sv ***
// Shared constants and types for the host port with delayed status views
package hpr_pkg;
    // Timing of late status updates
    localparam int CLK_NS = 40;
    localparam int TX_INFO_NS = 135;
    localparam int RX_INFO_NS = 135;
    localparam int DROP_NS = 180;
    // Longest times round down, never below one cycle
    localparam int TX_INFO_CYC = (TX_INFO_NS / CLK_NS < 1) ? 1 : TX_INFO_NS / CLK_NS;
    localparam int RX_INFO_CYC = (RX_INFO_NS / CLK_NS < 1) ? 1 : RX_INFO_NS / CLK_NS;
    localparam int DROP_CYC = (DROP_NS / CLK_NS < 1) ? 1 : DROP_NS / CLK_NS;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int TXF_DEPTH = 8;
    localparam int TXL_W = 4;
    localparam int RXL_W = 8;
    localparam int DROP_W = 16;

    // Word addresses on the host port
    localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_ID = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_BYTE_TEST = 6'h19;
    localparam logic [ADDR_W-1:0] ADDR_RX_INFO = 6'h1E;
    localparam logic [ADDR_W-1:0] ADDR_TX_INFO = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_RX_DROP = 6'h28;

    // Identity value is arbitrary
    localparam logic [DATA_W-1:0] ID_VALUE = 32'h0000_1234;
    // Byte order pattern is arbitrary, only needs four distinct bytes
    localparam logic [DATA_W-1:0] BYTE_TEST_VALUE = 32'hA5C3_0F96;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [DROP_W-1:0] DROP_ONE = 16'h0001;
    localparam logic [DROP_W-1:0] DROP_ZERO = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} hpr_state_t;
endpackage : hpr_pkg

// *** hpr_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module hpr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [CW-1:0] count_r, count_nxt;
    logic push, pop;

    assign inReady = count_r != FULL;
    assign outValid = count_r != '0;
    assign outData = mem_r[rdPtr_r];
    assign level = count_r;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (push) begin
            wrPtr_nxt = (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
        end
        if (pop) begin
            rdPtr_nxt = (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end
endmodule : hpr_fifo

// *** hpr_host_port.sv ***
// Strobe-framed host port with transmit FIFO and late-updating status views
//
// Summary of operation
// - Plain, burst, receive-FIFO direct and direct burst reads are served, framed by select and read strobe together.
// - Only writes to the transmit data address are taken, once per strobe, while select and write strobe are low; other writes are ignored.
// - The shown transmit FIFO level follows a write within at most 135 ns.
// - Side effects of some reads reach status views only after a delay.
// - A read starts when select and read strobe are both low and ends when either rises.
`timescale 1ns/1ps
module hpr_host_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic host_chip_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [hpr_pkg::ADDR_W-1:0] hostAddr,
    input wire logic hostFifoSel,
    input wire logic [hpr_pkg::DATA_W-1:0] hostWrData,
    output logic [hpr_pkg::DATA_W-1:0] hostRdData,
    output logic hostRdOe,
    output logic hostTxReady,
    output logic [hpr_pkg::DATA_W-1:0] txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic [hpr_pkg::DATA_W-1:0] rxData,
    input wire logic rxValid,
    output logic rxDataPop,
    input wire logic [hpr_pkg::RXL_W-1:0] rxLevel,
    input wire logic rxDropEvent
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int TXC = hpr_pkg::TX_INFO_CYC;
    localparam int RXC = hpr_pkg::RX_INFO_CYC;
    localparam int DRC = hpr_pkg::DROP_CYC;
    localparam int DATA_W = hpr_pkg::DATA_W;

    function automatic logic isRxData(input logic [hpr_pkg::ADDR_W-1:0] a, input logic sel);
        isRxData = sel || (a == hpr_pkg::ADDR_RX_DATA);
    endfunction : isRxData

    hpr_pkg::hpr_state_t state_r, state_nxt;
    logic [hpr_pkg::ADDR_W-1:0] addrPrev_r, addrPrev_nxt;
    logic [hpr_pkg::DATA_W-1:0] rdData_r, rdData_nxt;
    logic [hpr_pkg::DROP_W-1:0] dropCnt_r, dropCnt_nxt;
    logic [hpr_pkg::TXL_W-1:0] txPipe_r [TXC];
    logic [hpr_pkg::TXL_W-1:0] txPipe_nxt [TXC];
    logic [hpr_pkg::RXL_W-1:0] rxPipe_r [RXC];
    logic [hpr_pkg::RXL_W-1:0] rxPipe_nxt [RXC];
    logic [hpr_pkg::DROP_W-1:0] dropPipe_r [DRC];
    logic [hpr_pkg::DROP_W-1:0] dropPipe_nxt [DRC];
    logic [hpr_pkg::TXL_W-1:0] txLevel;
    logic readBoth, writeBoth, readStart, wordStep, txPush, dropClear;
    logic [hpr_pkg::DATA_W-1:0] readMux;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle framing
    assign readBoth = !host_chip_select_n && !host_read_strobe_n;
    assign writeBoth = !host_chip_select_n && !host_write_strobe_n;
    assign readStart = readBoth && (state_r != hpr_pkg::ST_READ);
    // A burst presents a new word each time the address moves under held strobes
    assign wordStep = readStart
        || (state_r == hpr_pkg::ST_READ && readBoth && hostAddr != addrPrev_r);
    assign txPush = writeBoth && (state_r != hpr_pkg::ST_WRITE)
        && hostAddr == hpr_pkg::ADDR_TX_DATA;
    assign rxDataPop = wordStep && isRxData(hostAddr, hostFifoSel) && rxValid;
    assign dropClear = wordStep && !hostFifoSel && hostAddr == hpr_pkg::ADDR_RX_DROP;
    assign hostRdOe = (state_r == hpr_pkg::ST_READ) && readBoth;
    assign hostRdData = rdData_r;

    always_comb begin
        readMux = hpr_pkg::DATA_ZERO;
        if (isRxData(hostAddr, hostFifoSel)) begin
            readMux = rxValid ? rxData : hpr_pkg::DATA_ZERO;
        end else begin
            unique case (hostAddr)
                hpr_pkg::ADDR_ID: readMux = hpr_pkg::ID_VALUE;
                hpr_pkg::ADDR_BYTE_TEST: readMux = hpr_pkg::BYTE_TEST_VALUE;
                hpr_pkg::ADDR_TX_INFO: readMux = DATA_W'(txPipe_r[TXC-1]);
                hpr_pkg::ADDR_RX_INFO: readMux = DATA_W'(rxPipe_r[RXC-1]);
                hpr_pkg::ADDR_RX_DROP: readMux = DATA_W'(dropPipe_r[DRC-1]);
                default: readMux = hpr_pkg::DATA_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port state, read data and drop counter
    always_comb begin
        state_nxt = readBoth ? hpr_pkg::ST_READ
            : (writeBoth ? hpr_pkg::ST_WRITE : hpr_pkg::ST_IDLE);
        addrPrev_nxt = hostAddr;
        rdData_nxt = wordStep ? readMux : rdData_r;
        // Event in the clearing cycle survives as a count of one
        if (dropClear) begin
            dropCnt_nxt = rxDropEvent ? hpr_pkg::DROP_ONE : hpr_pkg::DROP_ZERO;
        end else begin
            dropCnt_nxt = dropCnt_r + (rxDropEvent ? hpr_pkg::DROP_ONE : hpr_pkg::DROP_ZERO);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= hpr_pkg::ST_IDLE;
            addrPrev_r <= '0;
            rdData_r <= '0;
            dropCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            addrPrev_r <= addrPrev_nxt;
            rdData_r <= rdData_nxt;
            dropCnt_r <= dropCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Delayed status views; a fixed pipe bounds the lag even under back-to-back traffic
    always_comb begin
        txPipe_nxt[0] = txLevel;
        rxPipe_nxt[0] = rxLevel;
        dropPipe_nxt[0] = dropCnt_r;
        for (int i = 1; i < TXC; i++) begin
            txPipe_nxt[i] = txPipe_r[i-1];
        end
        for (int i = 1; i < RXC; i++) begin
            rxPipe_nxt[i] = rxPipe_r[i-1];
        end
        for (int i = 1; i < DRC; i++) begin
            dropPipe_nxt[i] = dropPipe_r[i-1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < TXC; i++) begin
                txPipe_r[i] <= '0;
            end
            for (int i = 0; i < RXC; i++) begin
                rxPipe_r[i] <= '0;
            end
            for (int i = 0; i < DRC; i++) begin
                dropPipe_r[i] <= '0;
            end
        end else begin
            txPipe_r <= txPipe_nxt;
            rxPipe_r <= rxPipe_nxt;
            dropPipe_r <= dropPipe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit data buffer; a full buffer drops the write, so the host watches ready
    hpr_fifo #(
        .WIDTH(hpr_pkg::DATA_W),
        .DEPTH(hpr_pkg::TXF_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(txPush),
        .inReady(hostTxReady),
        .inData(hostWrData),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txData),
        .level(txLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    chk_tx_info_lag: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 ##TXC 1'b1 |-> txPipe_r[TXC-1] == $past(txLevel, TXC))
        else $error("tx level view lag wrong");
    chk_rx_info_lag: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 ##RXC 1'b1 |-> rxPipe_r[RXC-1] == $past(rxLevel, RXC))
        else $error("rx level view lag wrong");
    chk_drop_view_lag: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 ##DRC 1'b1 |-> dropPipe_r[DRC-1] == $past(dropCnt_r, DRC))
        else $error("drop view lag wrong");
    chk_oe_both_low: assert property (@(posedge clk) disable iff (!resetn)
        hostRdOe |-> !host_chip_select_n && !host_read_strobe_n && $past(readBoth))
        else $error("read data driven outside a read");
    chk_pop_on_start: assert property (@(posedge clk) disable iff (!resetn)
        rxDataPop |-> rxValid && (readStart || hostAddr != addrPrev_r))
        else $error("rx pop without new read word");
    chk_id_read_data: assert property (@(posedge clk) disable iff (!resetn)
        readStart && !hostFifoSel && hostAddr == hpr_pkg::ADDR_ID
        |=> hostRdData == hpr_pkg::ID_VALUE)
        else $error("identity read data wrong");
    chk_tx_push_write: assert property (@(posedge clk) disable iff (!resetn)
        writeBoth && !$past(writeBoth) && hostAddr == hpr_pkg::ADDR_TX_DATA && hostTxReady
        && !txValid |=> txValid)
        else $error("tx write not buffered");
    chk_drop_set_wins: assert property (@(posedge clk) disable iff (!resetn)
        dropClear |=> dropCnt_r == ($past(rxDropEvent) ? hpr_pkg::DROP_ONE : hpr_pkg::DROP_ZERO))
        else $error("drop counter clear wrong");
endmodule : hpr_host_port

// *** hpr_mac_model.sv ***
// Far-side model: tx sink with back-pressure and rx word source
`timescale 1ns/1ps
module hpr_mac_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic pushEn,
    input wire logic [31:0] pushData,
    input wire logic dropEn,
    output logic txReady,
    output logic [31:0] rxData,
    output logic rxValid,
    input wire logic rxDataPop,
    output logic [7:0] rxLevel,
    output logic rxDropEvent
);
    logic [31:0] rxQ[$];
    logic [31:0] lastWord;
    integer seedP;
    initial begin
        seedP = 32;
        lastWord = 32'h0000_0000;
        txReady = 1'b0;
        rxData = 32'hFFFF_FFFF;
        rxValid = 1'b0;
        rxLevel = 8'h00;
    end
    assign rxDropEvent = dropEn;
    // Random stalls so the drain meets gaps as well as runs
    always @(posedge clk) begin
        txReady <= !stall && $random(seedP) % 2;
        if (rxDataPop && rxQ.size() > 0) begin
            lastWord = rxQ.pop_front();
        end
        if (pushEn) begin
            rxQ.push_back(pushData);
        end
        rxValid <= rxQ.size() > 0;
        rxLevel <= 8'(rxQ.size());
        // An empty source shows no stale word
        rxData <= rxQ.size() > 0 ? rxQ[0] : ~lastWord;
    end
endmodule : hpr_mac_model

// *** test_hpr_host_port.sv ***
// Self-checking bench for the host port against a queue model
`timescale 1ns/1ps
module test_hpr_host_port;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic csN = 1'b1;
    logic rdN = 1'b1;
    logic wrN = 1'b1;
    logic [5:0] addr = 6'h00;
    logic sel = 1'b0;
    logic [31:0] wrData = 32'h0000_0000;
    logic [31:0] pushData = 32'h0000_0000;
    logic stall = 1'b1;
    logic pushEn = 1'b0;
    logic dropEn = 1'b0;
    logic [31:0] rdData, txData, rxData;
    logic rdOe, txRdy, txValid, txReady, rxValid, rxDataPop, rxDropEvent;
    logic [7:0] rxLevel;
    logic [31:0] txM[$], rxM[$], gotQ[$];
    integer seed = 32;
    int n_fail = 0;
    int checks = 0;
    always #20 clk = ~clk;
    hpr_host_port uut (.clk, .resetn, .host_chip_select_n(csN), .host_read_strobe_n(rdN),
        .host_write_strobe_n(wrN), .hostAddr(addr), .hostFifoSel(sel), .hostWrData(wrData),
        .hostRdData(rdData), .hostRdOe(rdOe), .hostTxReady(txRdy), .txData, .txValid,
        .txReady, .rxData, .rxValid, .rxDataPop, .rxLevel, .rxDropEvent);
    hpr_mac_model mac (.clk, .stall, .pushEn, .pushData, .dropEn, .txReady, .rxData,
        .rxValid, .rxDataPop, .rxLevel, .rxDropEvent);
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task close_out;
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            chk(txData, txM.pop_front());
        end
    end
    // One word per cycle; address steps make a burst
    task rd(input logic [5:0] a, input logic s, input int n);
        @(posedge clk) #1;
        csN = 1'b0;
        rdN = 1'b0;
        for (int i = 0; i < n; i++) begin
            addr = a + 6'(i);
            sel = s;
            @(posedge clk) #1;
            gotQ.push_back(rdData);
            chk(32'(rdOe), 32'h1);
        end
        csN = 1'b1;
        rdN = 1'b1;
        #1 chk(32'(rdOe), 32'h0);
    endtask : rd
    task rd1(input logic [5:0] a, input logic [31:0] want, input logic [31:0] mask);
        rd(a, 1'b0, 1);
        chk(gotQ.pop_front() & mask, want);
    endtask : rd1
    task pad(input int n);
        repeat (n) rd1(hpr_pkg::ADDR_BYTE_TEST, hpr_pkg::BYTE_TEST_VALUE, '1);
    endtask : pad
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        chk(32'(txRdy), 32'(txM.size() < hpr_pkg::TXF_DEPTH));
        if (a == hpr_pkg::ADDR_TX_DATA && txM.size() < hpr_pkg::TXF_DEPTH) begin
            txM.push_back(d);
        end
        addr = a;
        wrData = d;
        csN = 1'b0;
        wrN = 1'b0;
        @(posedge clk) #1;
        csN = 1'b1;
        wrN = 1'b1;
    endtask : wr
    task pulse(input bit isDrop, input logic [31:0] d);
        @(posedge clk) #1;
        dropEn = isDrop;
        pushEn = !isDrop;
        pushData = d;
        if (!isDrop) begin
            rxM.push_back(d);
        end
        @(posedge clk) #1;
        dropEn = 1'b0;
        pushEn = 1'b0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        rd1(hpr_pkg::ADDR_ID, hpr_pkg::ID_VALUE, '1);
        rd1(6'h3F, 32'h0, '1);
        rd1(hpr_pkg::ADDR_RX_DATA, 32'h0, '1);
        repeat (3) pulse(1'b0, $random(seed));
        pad(2);
        rd1(hpr_pkg::ADDR_RX_INFO, 32'h3, 32'hFF);
        // Direct burst runs past the last word to show the empty answer
        rd(6'h10, 1'b1, 4);
        for (int i = 0; i < 4; i++) begin
            chk(gotQ.pop_front(), rxM.size() > 0 ? rxM.pop_front() : 32'h0);
        end
        pad(3);
        rd1(hpr_pkg::ADDR_RX_INFO, 32'h0, 32'hFF);
        repeat (9) wr(hpr_pkg::ADDR_TX_DATA, $random(seed));
        // Identity needs no wait after a write, so it may follow at once
        rd1(hpr_pkg::ADDR_ID, hpr_pkg::ID_VALUE, '1);
        wr(hpr_pkg::ADDR_ID, $random(seed));
        pad(2);
        rd1(hpr_pkg::ADDR_TX_INFO, 32'h8, 32'hF);
        stall = 1'b0;
        repeat (5) wr(hpr_pkg::ADDR_TX_DATA, $random(seed));
        pad(3);
        for (int k = 0; k < 300 && txM.size() > 0; k++) begin
            @(posedge clk);
        end
        chk(32'(txM.size()), 32'h0);
        pad(2);
        rd1(hpr_pkg::ADDR_TX_INFO, 32'h0, 32'hF);
        repeat (3) pulse(1'b1, 32'h0);
        pad(3);
        rd1(hpr_pkg::ADDR_RX_DROP, 32'h3, 32'hFFFF);
        pad(4);
        rd1(hpr_pkg::ADDR_RX_DROP, 32'h0, 32'hFFFF);
        close_out();
    end
endmodule : test_hpr_host_port
